// >>> rtl/pcbr_map.svh
// Offsets, field ranges, constant field values and reset values of the
// configuration registers. Included by the package and the design modules.
`ifndef PCBR_MAP_SVH
`define PCBR_MAP_SVH

// Dword-aligned configuration offsets
`define PCBR_OFS_MEM_BASE   8'h14
`define PCBR_OFS_SUBSYS_ID  8'h2C
`define PCBR_OFS_BOOT_ROM   8'h30
`define PCBR_OFS_CAP_PTR    8'h34
`define PCBR_DW_MASK        8'hFC

// Memory window register fields
`define PCBR_MEM_ADDR_RNG   31:12
`define PCBR_MEM_SIZE_RNG   11:4
`define PCBR_MEM_PF_BIT     3
`define PCBR_MEM_LOC_RNG    2:1
`define PCBR_MEM_IND_BIT    0
`define PCBR_MEM_SIZE_VAL   8'h00
`define PCBR_MEM_PF_VAL     1'h0
`define PCBR_MEM_LOC_VAL    2'h0
`define PCBR_MEM_IND_VAL    1'h0
`define PCBR_MEM_WR_MASK    32'hFFFFF000
`define PCBR_MEM_OFS_RNG    11:0

// Boot ROM window register fields
`define PCBR_ROM_ADDR_RNG   31:16
`define PCBR_ROM_ZERO_RNG   15:1
`define PCBR_ROM_SEL_BIT    0
`define PCBR_ROM_SIZE_VAL   5'h00
`define PCBR_ROM_UNUSED_VAL 10'h000
`define PCBR_ROM_WR_MASK    32'hFFFF0001
`define PCBR_ROM_OFS_RNG    15:0

// Subsystem identity and capability pointer
`define PCBR_SID_DEV_RNG    31:16
`define PCBR_SID_VEN_RNG    15:0
`define PCBR_CAP_UNUSED_VAL 24'h000000
`define PCBR_CAP_PTR_VAL    8'h40

// Reset values and widths
`define PCBR_MEM_ADDR_W     20
`define PCBR_ROM_ADDR_W     16
`define PCBR_CODE_W         16
`define PCBR_BYTE_W         8
`define PCBR_LANES          4
`define PCBR_MEM_ADDR_RST   20'h00000
`define PCBR_ROM_ADDR_RST   16'h0000
`define PCBR_ROM_SEL_RST    1'h0

`endif

// >>> rtl/pcbr_pkg.sv
// Carrier and state types of the configuration register block.
// Assumes the map header is on the include path.
`include "pcbr_map.svh"
package pcbr_pkg;
    typedef struct packed {
        logic                        valid;
        logic                        write;
        logic [7:0]                  addr;
        logic [`PCBR_LANES-1:0]      byte_en;
        logic [31:0]                 wdata;
    } pcbr_cfg_req_type;

    typedef struct packed {
        logic                        ack;
        logic                        hit;
        logic [31:0]                 rdata;
    } pcbr_cfg_rsp_type;

    typedef struct packed {
        logic                        valid;
        logic [31:0]                 addr;
    } pcbr_mem_req_type;

    typedef struct packed {
        logic                        reg_hit;
        logic                        rom_hit;
        logic [15:0]                 offset;
    } pcbr_mem_rsp_type;

    typedef struct packed {
        logic                        valid;
        logic                        enable;
        logic [`PCBR_CODE_W-1:0]     subsys_device_code;
        logic [`PCBR_CODE_W-1:0]     subsys_vendor_code;
    } pcbr_ee_load_type;

    typedef struct packed {
        logic [`PCBR_CODE_W-1:0]     subsys_device_code;
        logic [`PCBR_CODE_W-1:0]     subsys_vendor_code;
    } pcbr_sid_state_type;

    typedef struct packed {
        logic [`PCBR_MEM_ADDR_W-1:0] mem_window_addr;
        logic [`PCBR_ROM_ADDR_W-1:0] boot_window_addr;
        logic                        boot_decode_select;
        pcbr_cfg_rsp_type            rsp;
    } pcbr_regs_state_type;
endpackage

// >>> rtl/pcbr_subsys_id.sv
// Subsystem identity holder, loaded from the EEPROM configuration load.
// Assumes the loader drives ee_load for one cycle per loaded word pair.
`timescale 1ns/1ps
`include "pcbr_map.svh"
module pcbr_subsys_id #(
    parameter logic [31:0] SUBSYS_ID_DEFAULT = 32'h5EED0001 // Arbitrary value
) (
    input  wire                            clk,
    input  wire                            sys_rst,
    input  wire pcbr_pkg::pcbr_ee_load_type ee_load,
    output pcbr_pkg::pcbr_sid_state_type   sid
);
    pcbr_pkg::pcbr_sid_state_type state;
    pcbr_pkg::pcbr_sid_state_type next_state;

    // Load only while EEPROM configuration is enabled
    always_comb begin
        next_state = state;
        if (ee_load.valid && ee_load.enable) begin
            next_state.subsys_device_code = ee_load.subsys_device_code;
            next_state.subsys_vendor_code = ee_load.subsys_vendor_code;
        end
    end

    // Hard reset only; soft reset never reaches here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= SUBSYS_ID_DEFAULT;
        end else begin
            state <= next_state;
        end
    end

    assign sid = state;

    property p_ee_load;
        @(posedge clk) disable iff (sys_rst)
        (ee_load.valid && ee_load.enable) |=>
            (sid == {$past(ee_load.subsys_device_code), $past(ee_load.subsys_vendor_code)});
    endproperty
    a_ee_load: assert property (p_ee_load) else $error("subsystem id not loaded");

    property p_ee_blocked;
        @(posedge clk) disable iff (sys_rst)
        !(ee_load.valid && ee_load.enable) |=> $stable(sid);
    endproperty
    a_ee_blocked: assert property (p_ee_blocked) else $error("subsystem id changed");

    c_ee_load: cover property (@(posedge clk) ee_load.valid && ee_load.enable);
endmodule // pcbr_subsys_id

// >>> rtl/pcbr_window_decode.sv
// Memory-space decode of the register window and the boot ROM window.
// Assumes the command register's memory enable is on this clock.
`timescale 1ns/1ps
`include "pcbr_map.svh"
module pcbr_window_decode (
    input  wire                              clk,
    input  wire                              sys_rst,
    input  wire                              memory_space_enable,
    input  wire pcbr_pkg::pcbr_mem_req_type  mem_req,
    input  wire [`PCBR_MEM_ADDR_W-1:0]       mem_window_addr,
    input  wire [`PCBR_ROM_ADDR_W-1:0]       boot_window_addr,
    input  wire                              boot_decode_select,
    output pcbr_pkg::pcbr_mem_rsp_type       mem_rsp
);
    pcbr_pkg::pcbr_mem_rsp_type state;
    pcbr_pkg::pcbr_mem_rsp_type next_state;
    logic                       take;

    // Shared decoder: ROM select steals it from the register window
    assign take = mem_req.valid && memory_space_enable;
    always_comb begin
        next_state = '0;
        if (take && boot_decode_select) begin
            next_state.rom_hit = (mem_req.addr[`PCBR_ROM_ADDR_RNG] == boot_window_addr);
            next_state.offset  = mem_req.addr[`PCBR_ROM_OFS_RNG];
        end else if (take) begin
            next_state.reg_hit = (mem_req.addr[`PCBR_MEM_ADDR_RNG] == mem_window_addr);
            next_state.offset  = {4'h0, mem_req.addr[`PCBR_MEM_OFS_RNG]};
        end
    end

    // Hits are one-cycle pulses
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign mem_rsp = state;

    property p_no_enable;
        @(posedge clk) disable iff (sys_rst)
        !memory_space_enable |=> !mem_rsp.reg_hit && !mem_rsp.rom_hit;
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("hit while disabled");

    property p_rom_blocks;
        @(posedge clk) disable iff (sys_rst)
        boot_decode_select |=> !mem_rsp.reg_hit;
    endproperty
    a_rom_blocks: assert property (p_rom_blocks) else $error("register hit under ROM");

    property p_reg_decode;
        @(posedge clk) disable iff (sys_rst)
        (take && !boot_decode_select && mem_req.addr[`PCBR_MEM_ADDR_RNG] == mem_window_addr)
            |=> mem_rsp.reg_hit;
    endproperty
    a_reg_decode: assert property (p_reg_decode) else $error("register window missed");

    c_rom_hit: cover property (@(posedge clk) mem_rsp.rom_hit);
    c_reg_hit: cover property (@(posedge clk) mem_rsp.reg_hit);
endmodule // pcbr_window_decode

// >>> rtl/pcbr_cfg_regs.sv
// Configuration header slice: memory window base, subsystem identity,
// boot ROM window with decode select, and capability pointer.
// Assumes configuration requests come from logic on clk, one at a time.
//
// Behaviour
// - Memory base bits 31..12 are writable and hold the register window base.
// - Memory base bits 11..4 read zero, asking for a 4096-byte window.
// - Memory base bit 3 reads zero: not prefetchable, read-only.
// - Memory base bits 2..1 read 00: 32-bit base anywhere, read-only.
// - Memory base bit 0 reads zero: memory space, read-only.
// - Subsystem word is read-only, device code high, vendor code low.
// - EEPROM load overwrites subsystem codes only when loading is enabled.
// - Boot ROM bits 31..16 are a writable ROM window base.
// - Boot ROM bits 15..1 read zero, asking for a 64 KB window.
// - Boot ROM bit 0 set sends the shared decode to ROM, blocking registers.
// - Capability pointer reads 40h in the low byte, zero above, read-only.
// - Memory accesses answer only while memory space is enabled.
`timescale 1ns/1ps
`include "pcbr_map.svh"
module pcbr_cfg_regs #(
    parameter logic [31:0] SUBSYS_ID_DEFAULT = 32'h5EED0001 // Arbitrary value
) (
    input  wire                              clk,
    input  wire                              sys_rst,
    input  wire pcbr_pkg::pcbr_cfg_req_type  cfg_req,
    output pcbr_pkg::pcbr_cfg_rsp_type       cfg_rsp,
    input  wire                              memory_space_enable,
    input  wire pcbr_pkg::pcbr_mem_req_type  mem_req,
    output pcbr_pkg::pcbr_mem_rsp_type       mem_rsp,
    input  wire pcbr_pkg::pcbr_ee_load_type  ee_load,
    output logic [`PCBR_MEM_ADDR_W-1:0]      mem_window_addr,
    output logic [`PCBR_ROM_ADDR_W-1:0]      boot_window_addr,
    output logic                             boot_decode_select
);
    localparam pcbr_pkg::pcbr_regs_state_type RESET_STATE = '{
        mem_window_addr:    `PCBR_MEM_ADDR_RST,
        boot_window_addr:   `PCBR_ROM_ADDR_RST,
        boot_decode_select: `PCBR_ROM_SEL_RST,
        rsp:                '0
    };

    pcbr_pkg::pcbr_regs_state_type state;
    pcbr_pkg::pcbr_regs_state_type next_state;
    pcbr_pkg::pcbr_sid_state_type  sid;

    logic [7:0]  dword_addr;
    logic [31:0] lane_mask;
    logic [31:0] mem_word;
    logic [31:0] rom_word;
    logic [31:0] sid_word;
    logic [31:0] cap_word;
    logic [31:0] mem_merged;
    logic [31:0] rom_merged;
    logic [31:0] read_word;
    logic        sel_mem;
    logic        sel_sid;
    logic        sel_rom;
    logic        sel_cap;
    logic        wr_mem;
    logic        wr_rom;
    logic        rd_mem;
    logic        rd_rom;

    // Subsystem identity lives with its loader
    pcbr_subsys_id #(
        .SUBSYS_ID_DEFAULT (SUBSYS_ID_DEFAULT)
    ) u_subsys_id (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ee_load (ee_load),
        .sid     (sid)
    );

    // Window decode sees the live bases, so a rewrite takes effect next access
    pcbr_window_decode u_window_decode (
        .clk                 (clk),
        .sys_rst             (sys_rst),
        .memory_space_enable (memory_space_enable),
        .mem_req             (mem_req),
        .mem_window_addr     (state.mem_window_addr),
        .boot_window_addr    (state.boot_window_addr),
        .boot_decode_select  (state.boot_decode_select),
        .mem_rsp             (mem_rsp)
    );

    // Byte enables widened to a bit mask
    for (genvar b = 0; b < `PCBR_LANES; b++) begin : g_lane
        assign lane_mask[b*`PCBR_BYTE_W +: `PCBR_BYTE_W] = {`PCBR_BYTE_W{cfg_req.byte_en[b]}};
    end

    // Sub-dword byte address bits do not pick a register
    assign dword_addr = cfg_req.addr & `PCBR_DW_MASK;
    assign sel_mem    = (dword_addr == `PCBR_OFS_MEM_BASE);
    assign sel_sid    = (dword_addr == `PCBR_OFS_SUBSYS_ID);
    assign sel_rom    = (dword_addr == `PCBR_OFS_BOOT_ROM);
    assign sel_cap    = (dword_addr == `PCBR_OFS_CAP_PTR);
    assign wr_mem     = cfg_req.valid && cfg_req.write && sel_mem;
    assign wr_rom     = cfg_req.valid && cfg_req.write && sel_rom;
    assign rd_mem     = cfg_req.valid && !cfg_req.write && sel_mem;
    assign rd_rom     = cfg_req.valid && !cfg_req.write && sel_rom;

    // Read images: constant fields are wired, never stored
    assign mem_word = {state.mem_window_addr,
                       `PCBR_MEM_SIZE_VAL,
                       `PCBR_MEM_PF_VAL,
                       `PCBR_MEM_LOC_VAL,
                       `PCBR_MEM_IND_VAL};
    assign sid_word = {sid.subsys_device_code, sid.subsys_vendor_code};
    assign rom_word = {state.boot_window_addr,
                       `PCBR_ROM_SIZE_VAL,
                       `PCBR_ROM_UNUSED_VAL,
                       state.boot_decode_select};
    assign cap_word = {`PCBR_CAP_UNUSED_VAL, `PCBR_CAP_PTR_VAL};

    // Only writable bits under an enabled lane take the new data
    assign mem_merged = (mem_word & ~(lane_mask & `PCBR_MEM_WR_MASK))
                      | (cfg_req.wdata & lane_mask & `PCBR_MEM_WR_MASK);
    assign rom_merged = (rom_word & ~(lane_mask & `PCBR_ROM_WR_MASK))
                      | (cfg_req.wdata & lane_mask & `PCBR_ROM_WR_MASK);

    // Read mux; other offsets belong to neighbours and read zero here
    always_comb begin
        read_word = '0;
        if (sel_mem) begin
            read_word = mem_word;
        end else if (sel_sid) begin
            read_word = sid_word;
        end else if (sel_rom) begin
            read_word = rom_word;
        end else if (sel_cap) begin
            read_word = cap_word;
        end
    end

    // Next state: writes to the two windows, one-cycle answer to every request
    always_comb begin
        next_state           = state;
        next_state.rsp.ack   = cfg_req.valid;
        next_state.rsp.hit   = cfg_req.valid && (sel_mem || sel_sid || sel_rom || sel_cap);
        next_state.rsp.rdata = '0;
        if (cfg_req.valid && !cfg_req.write) begin
            next_state.rsp.rdata = read_word;
        end
        if (wr_mem) begin
            next_state.mem_window_addr = mem_merged[`PCBR_MEM_ADDR_RNG];
        end
        if (wr_rom) begin
            next_state.boot_window_addr   = rom_merged[`PCBR_ROM_ADDR_RNG];
            next_state.boot_decode_select = rom_merged[`PCBR_ROM_SEL_BIT];
        end
    end

    // Hard reset only; soft reset leaves these untouched
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    // Outputs are register fields
    assign cfg_rsp            = state.rsp;
    assign mem_window_addr    = state.mem_window_addr;
    assign boot_window_addr   = state.boot_window_addr;
    assign boot_decode_select = state.boot_decode_select;

    // Checks on what software sees
    property p_mem_base_write;
        @(posedge clk) disable iff (sys_rst)
        (wr_mem && cfg_req.byte_en == 4'hF) |=>
            (mem_window_addr == $past(cfg_req.wdata[`PCBR_MEM_ADDR_RNG]));
    endproperty
    a_mem_base_write: assert property (p_mem_base_write)
        else $error("memory base not written");

    property p_mem_size_zero;
        @(posedge clk) disable iff (sys_rst)
        rd_mem |=> cfg_rsp.ack && (cfg_rsp.rdata[`PCBR_MEM_SIZE_RNG] == 8'h00);
    endproperty
    a_mem_size_zero: assert property (p_mem_size_zero)
        else $error("memory size bits not zero");

    property p_mem_prefetch;
        @(posedge clk) disable iff (sys_rst)
        rd_mem |=> !cfg_rsp.rdata[`PCBR_MEM_PF_BIT];
    endproperty
    a_mem_prefetch: assert property (p_mem_prefetch)
        else $error("prefetch flag set");

    property p_mem_placement;
        @(posedge clk) disable iff (sys_rst)
        rd_mem |=> (cfg_rsp.rdata[`PCBR_MEM_LOC_RNG] == 2'h0);
    endproperty
    a_mem_placement: assert property (p_mem_placement)
        else $error("placement type not 00");

    property p_mem_space;
        @(posedge clk) disable iff (sys_rst)
        rd_mem |=> !cfg_rsp.rdata[`PCBR_MEM_IND_BIT];
    endproperty
    a_mem_space: assert property (p_mem_space)
        else $error("space flag set");

    property p_sid_read;
        @(posedge clk) disable iff (sys_rst)
        (cfg_req.valid && !cfg_req.write && sel_sid) |=>
            cfg_rsp.hit && (cfg_rsp.rdata == $past(sid_word));
    endproperty
    a_sid_read: assert property (p_sid_read)
        else $error("subsystem word wrong");

    property p_rom_base_write;
        @(posedge clk) disable iff (sys_rst)
        (wr_rom && cfg_req.byte_en == 4'hF) |=>
            (boot_window_addr == $past(cfg_req.wdata[`PCBR_ROM_ADDR_RNG]))
            && (boot_decode_select == $past(cfg_req.wdata[`PCBR_ROM_SEL_BIT]));
    endproperty
    a_rom_base_write: assert property (p_rom_base_write)
        else $error("boot ROM register not written");

    property p_rom_zero;
        @(posedge clk) disable iff (sys_rst)
        rd_rom |=> (cfg_rsp.rdata[`PCBR_ROM_ZERO_RNG] == 15'h0000);
    endproperty
    a_rom_zero: assert property (p_rom_zero)
        else $error("boot ROM low bits not zero");

    property p_cap_read;
        @(posedge clk) disable iff (sys_rst)
        (cfg_req.valid && !cfg_req.write && sel_cap) |=> (cfg_rsp.rdata == 32'h00000040);
    endproperty
    a_cap_read: assert property (p_cap_read)
        else $error("capability pointer wrong");

    property p_sizing;
        @(posedge clk) disable iff (sys_rst)
        (wr_mem && cfg_req.wdata == 32'hFFFFFFFF && cfg_req.byte_en == 4'hF) ##1 rd_mem
            |=> (cfg_rsp.rdata == 32'hFFFFF000);
    endproperty
    a_sizing: assert property (p_sizing)
        else $error("sizing read wrong");

    property p_ack_once;
        @(posedge clk) disable iff (sys_rst)
        cfg_req.valid |=> cfg_rsp.ack ##1 (cfg_rsp.ack == $past(cfg_req.valid));
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("answer timing wrong");

    property p_mem_read;
        @(posedge clk) disable iff (sys_rst)
        rd_mem |=> (cfg_rsp.rdata[`PCBR_MEM_ADDR_RNG] == $past(mem_window_addr));
    endproperty
    a_mem_read: assert property (p_mem_read)
        else $error("memory base misread");

    property p_mem_hold;
        @(posedge clk) disable iff (sys_rst)
        !wr_mem |=> $stable(mem_window_addr);
    endproperty
    a_mem_hold: assert property (p_mem_hold)
        else $error("memory base changed unasked");

    property p_mem_low_lane;
        @(posedge clk) disable iff (sys_rst)
        (wr_mem && cfg_req.byte_en[3:1] == 3'h0) |=> $stable(mem_window_addr);
    endproperty
    a_mem_low_lane: assert property (p_mem_low_lane)
        else $error("read-only byte moved base");

    property p_rom_read;
        @(posedge clk) disable iff (sys_rst)
        rd_rom |=> (cfg_rsp.rdata[`PCBR_ROM_ADDR_RNG] == $past(boot_window_addr))
            && (cfg_rsp.rdata[`PCBR_ROM_SEL_BIT] == $past(boot_decode_select));
    endproperty
    a_rom_read: assert property (p_rom_read)
        else $error("boot ROM register misread");

    property p_rom_hold;
        @(posedge clk) disable iff (sys_rst)
        !wr_rom |=> $stable(boot_window_addr) && $stable(boot_decode_select);
    endproperty
    a_rom_hold: assert property (p_rom_hold)
        else $error("boot ROM register changed unasked");

    property p_rom_lane_off;
        @(posedge clk) disable iff (sys_rst)
        (wr_rom && !cfg_req.byte_en[0]) |=> $stable(boot_decode_select);
    endproperty
    a_rom_lane_off: assert property (p_rom_lane_off)
        else $error("decode select moved with lane off");

    property p_sid_no_write;
        @(posedge clk) disable iff (sys_rst)
        (cfg_req.valid && cfg_req.write && sel_sid && !(ee_load.valid && ee_load.enable))
            |=> $stable(sid_word);
    endproperty
    a_sid_no_write: assert property (p_sid_no_write)
        else $error("subsystem word written");

    property p_write_quiet;
        @(posedge clk) disable iff (sys_rst)
        (cfg_req.valid && cfg_req.write) |=> cfg_rsp.ack && (cfg_rsp.rdata == 32'h00000000);
    endproperty
    a_write_quiet: assert property (p_write_quiet)
        else $error("write answered with data");

    c_sizing: cover property (@(posedge clk) wr_mem && cfg_req.wdata == 32'hFFFFFFFF);
    c_rom_enable: cover property (@(posedge clk) $rose(boot_decode_select));
    c_cap_read: cover property (@(posedge clk) cfg_req.valid && sel_cap);
endmodule // pcbr_cfg_regs

// >>> sim/pcbr_host_model.sv
// Host bridge model issuing configuration and memory cycles.
// Assumes the block answers one clk edge after each taken request.
`timescale 1ns/1ps
module pcbr_host_model (
    input  wire                             clk,
    input  wire pcbr_pkg::pcbr_cfg_rsp_type cfg_rsp,
    input  wire pcbr_pkg::pcbr_mem_rsp_type mem_rsp,
    output pcbr_pkg::pcbr_cfg_req_type      cfg_req,
    output pcbr_pkg::pcbr_mem_req_type      mem_req
);
    // Idle bus at time zero
    initial begin
        cfg_req = '0;
        mem_req = '0;
    end

    // One config cycle; released lines are inverted so stale data never matches
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] wd, output logic hit, output logic [31:0] rd,
                       output logic ok);
        @(negedge clk);
        cfg_req = {1'b1, wr, a, be, wd};
        // Answer stands only in the cycle after the take edge
        @(negedge clk);
        cfg_req = {1'b0, ~wr, ~a, ~be, ~wd};
        ok = (cfg_rsp.ack === 1'b1);
        hit = cfg_rsp.hit;
        rd = cfg_rsp.rdata;
    endtask

    // One memory access; the answer is fixed one edge after the take
    task automatic mem(input logic [31:0] a, output pcbr_pkg::pcbr_mem_rsp_type r);
        @(negedge clk);
        mem_req = {1'b1, a};
        @(negedge clk);
        mem_req = {1'b0, ~a};
        r = mem_rsp;
    endtask
endmodule // pcbr_host_model

// >>> sim/pcbr_cfg_regs_test.sv
// Self-checking bench of the configuration register slice.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/1ps
module pcbr_cfg_regs_test;
    logic                       clk;
    logic                       sys_rst;
    logic                       memory_space_enable;
    pcbr_pkg::pcbr_cfg_req_type cfg_req;
    pcbr_pkg::pcbr_cfg_rsp_type cfg_rsp;
    pcbr_pkg::pcbr_mem_req_type mem_req;
    pcbr_pkg::pcbr_mem_rsp_type mem_rsp;
    pcbr_pkg::pcbr_ee_load_type ee_load;
    pcbr_pkg::pcbr_mem_rsp_type mr;
    logic [19:0]                mem_window_addr;
    logic [15:0]                boot_window_addr;
    logic                       boot_decode_select;
    logic [31:0]                rd, mem_exp, rom_exp, wv, sid;
    logic [15:0]                off;
    logic [3:0]                 be;
    logic                       hit;
    int                         mismatches, checks;

    // Zero default so the subsystem word resets as documented
    pcbr_cfg_regs #(.SUBSYS_ID_DEFAULT(32'h00000000)) uut (
        .clk(clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
        .memory_space_enable(memory_space_enable), .mem_req(mem_req),
        .mem_rsp(mem_rsp), .ee_load(ee_load), .mem_window_addr(mem_window_addr),
        .boot_window_addr(boot_window_addr), .boot_decode_select(boot_decode_select));

    pcbr_host_model host (
        .clk(clk), .cfg_rsp(cfg_rsp), .mem_rsp(mem_rsp), .cfg_req(cfg_req),
        .mem_req(mem_req));

    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Lane merge through the writable mask of a register
    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd,
                                          logic [3:0] lanes, logic [31:0] wmask);
        logic [31:0] m;
        for (int b = 0; b < 4; b++) m[8*b+:8] = {8{lanes[b]}};
        m = m & wmask;
        return (old & ~m) | (wd & m);
    endfunction

    // Expected decode answer: a taken access compares against one window only
    function automatic logic [31:0] dec_exp(logic en, logic sel, logic [31:0] a);
        dec_exp = 32'h00000000;
        if (en && sel) dec_exp = {15'h0000, a[31:16] == 16'h5000, a[15:0]};
        else if (en) dec_exp = {14'h0000, a[31:12] == 20'h40003, 5'h00, a[11:0]};
    endfunction

    // Config access; a missing answer ends the run
    task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] lanes,
                       input logic [31:0] wd);
        logic ok;
        host.cfg(wr, a, lanes, wd, hit, rd, ok);
        if (!ok) begin
            mismatches++;
            $display("[FAIL] cfg ack expected 1 seen 0");
            tally_and_finish();
        end
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp,
                          input logic exp_hit);
        acc(1'b0, a, 4'hF, 32'h00000000);
        check(name, exp, rd);
        check("hit", {31'h0, exp_hit}, {31'h0, hit});
    endtask

    // Main sequence; inputs change at falling edges only
    initial begin
        sys_rst = 1'b1;
        memory_space_enable = 1'b0;
        ee_load = '0;
        mismatches = 0;
        checks = 0;
        wv = $urandom(32'h541A);
        repeat (3) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        @(posedge clk);
        rd_chk("mem base", 8'h14, 32'h00000000, 1'b1);
        rd_chk("subsys", 8'h2C, 32'h00000000, 1'b1);
        rd_chk("rom", 8'h30, 32'h00000000, 1'b1);
        rd_chk("cap ptr", 8'h34, 32'h00000040, 1'b1);
        rd_chk("unmapped", 8'h38, 32'h00000000, 1'b0);
        $display("test reset done");
        // Sizing writes of all ones must leave constant bits alone
        acc(1'b1, 8'h14, 4'hF, 32'hFFFFFFFF);
        acc(1'b1, 8'h2C, 4'hF, 32'hFFFFFFFF);
        acc(1'b1, 8'h30, 4'hF, 32'hFFFFFFFF);
        acc(1'b1, 8'h34, 4'hF, 32'hFFFFFFFF);
        rd_chk("mem size", 8'h14, 32'hFFFFF000, 1'b1);
        rd_chk("rom size", 8'h30, 32'hFFFF0001, 1'b1);
        rd_chk("subsys ro", 8'h2C, 32'h00000000, 1'b1);
        rd_chk("cap ro", 8'h34, 32'h00000040, 1'b1);
        check("mem port", 32'h000FFFFF, {12'h0, mem_window_addr});
        check("rom port", 32'h0001FFFF, {15'h0, boot_window_addr, boot_decode_select});
        $display("test sizing done");
        // Random data and lane enables
        mem_exp = 32'hFFFFF000;
        rom_exp = 32'hFFFF0001;
        repeat (20) begin
            wv = $urandom;
            be = 4'($urandom);
            acc(1'b1, 8'h14, be, wv);
            acc(1'b1, 8'h31, be, ~wv);
            mem_exp = merge(mem_exp, wv, be, 32'hFFFFF000);
            rom_exp = merge(rom_exp, ~wv, be, 32'hFFFF0001);
            rd_chk("mem rand", 8'h14, mem_exp, 1'b1);
            rd_chk("rom rand", 8'h32, rom_exp, 1'b1);
        end
        $display("test random done");
        // Decode against enable and ROM select, every combination
        acc(1'b1, 8'h14, 4'hF, 32'h40003000);
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, 8'h30, 4'hF, {16'h5000, 15'h0, c[1]});
            memory_space_enable = c[0];
            off = 16'($urandom) & 16'h0FFF;
            wv = 32'h40003000 | 32'(off);
            host.mem(wv, mr);
            check("reg dec", dec_exp(c[0], c[1], wv), 32'(mr));
            wv = {16'h5000, 16'($urandom)};
            host.mem(wv, mr);
            check("rom dec", dec_exp(c[0], c[1], wv), 32'(mr));
            host.mem(32'h40004000, mr);
            check("outside", dec_exp(c[0], c[1], 32'h40004000), 32'(mr));
        end
        $display("test decode done");
        // Load ignored while loading is disabled, taken when enabled
        for (int e = 0; e < 2; e++) begin
            wv = $urandom;
            @(negedge clk);
            ee_load = {1'b1, e[0], wv};
            @(negedge clk);
            ee_load = {1'b0, ~e[0], ~wv};
            sid = e == 1 ? wv : 32'h0;
            rd_chk("subsys load", 8'h2C, sid, 1'b1);
        end
        $display("test load done");
        tally_and_finish();
    end
endmodule // pcbr_cfg_regs_test
